// file: core/cam_inq_pkg.sv
// package for the camera capability inquiry register bank
// assumes quadlet (32-bit) register access from a 1394 link layer
package cam_inq_pkg;

   // ==========================================================
   // address map
   localparam logic [31:0] CMD_BASE = 32'hf0f00000;
   localparam logic [11:0] OFF_INIT = 12'h000;
   localparam logic [11:0] OFF_FMT = 12'h100;
   localparam logic [11:0] OFF_MODE_F0 = 12'h180;
   localparam logic [11:0] OFF_MODE_F1 = 12'h184;
   localparam logic [11:0] OFF_MODE_F2 = 12'h188;
   localparam logic [11:0] OFF_MODE_RSV_LO = 12'h18c;
   localparam logic [11:0] OFF_MODE_RSV_HI = 12'h197;
   localparam logic [11:0] OFF_MODE_F6 = 12'h198;
   localparam logic [11:0] OFF_MODE_F7 = 12'h19c;
   localparam logic [11:0] OFF_RATE_F0M0 = 12'h200;
   localparam logic [11:0] OFF_RATE_F0M1 = 12'h204;
   localparam logic [11:0] OFF_RATE_F0M2 = 12'h208;
   localparam logic [11:0] OFF_RATE_F0M3 = 12'h20c;
   localparam logic [11:0] OFF_RATE_F0M4 = 12'h210;

   // ==========================================================
   // field layout (bit 0 is the msb of the quadlet)
   localparam int INIT_BIT = 31;
   localparam logic [7:0] MASK_FMT = 8'hc7;
   localparam logic [7:0] MASK_MODE_F0 = 8'h7f;
   localparam logic [7:0] MASK_FULL = 8'hff;
   localparam logic [7:0] MASK_RATE_F0M0 = 8'hfc;

   // ==========================================================
   // default capabilities, documented bit order, index k = bit k
   localparam logic [7:0] DEF_FMT = 8'h87;
   localparam logic [7:0] DEF_MODE_F0 = 8'h7f;
   localparam logic [7:0] DEF_MODE_FX = 8'hff;
   localparam logic [7:0] DEF_RATE = 8'hff;

   // ==========================================================
   // 1394 response codes
   localparam logic [3:0] RCODE_COMPLETE = 4'h0;
   localparam logic [3:0] RCODE_ADDR_ERR = 4'h7;
   localparam logic [31:0] RESET_DATA = 32'h00000000;

   // ==========================================================
   // initialisation timing
   localparam int CLK_MHZ = 20;
   localparam int INIT_TIME_NS = 1000;
   localparam int INIT_CYCLES_I = (INIT_TIME_NS * CLK_MHZ) / 1000;
   localparam logic [7:0] INIT_CYCLES = 8'(INIT_CYCLES_I);

   typedef enum logic [0:0] {ST_IDLE, ST_INIT} initState_t;

endpackage : cam_inq_pkg

// file: core/inquiry_word.sv
// one inquiry quadlet built from eight capability flags
// assumes flags are given in documented order, index k is bit k
`timescale 1ns/1ps
module inquiry_word (
   input wire logic [7:0] flags,
   input wire logic [7:0] mask,
   output logic [31:0] quad
);

   // ==========================================================
   // flag k lands at quadlet bit 31-k, low 24 bits always zero
   for (genvar k = 0; k < 8; k++) begin : g_bit
      assign quad[31-k] = flags[k] & mask[k]; // R12
   end
   assign quad[23:0] = 24'h000000;

endmodule : inquiry_word

// file: core/camera_capability_inquiry_regs.sv
// camera initialise control and capability inquiry registers
// assumes a 1394 link layer on the same clock presents one quadlet
// request per cycle at most, lower 32 address bits only
`timescale 1ns/1ps

// Contract
// R1 - every register decodes at its offset above base f0f00000h
// R2 - writing one to msb of offset 000h starts a full initialisation
// R3 - offset 100h bits 0..2 flag the three basic formats
// R4 - format bits 3..5 and 8..31 reserved; 6 still, 7 partial image
// R5 - 180h flags format 0 modes 0..6; bit 7 and up read zero
// R6 - 184h and 188h flag formats 1 and 2 modes 0..7
// R7 - offsets 18ch to 197h and still modes at 198h read zero
// R8 - 19ch flags partial image modes 0..7, upper bits zero
// R9 - rate registers from 200h flag eight rates in bits 0..7
// R10 - format 0 mode 0 lacks two slow rates; modes 1..4 all
// R11 - register set follows the standard camera set, noted deviations
// R12 - bit 0 is the most significant bit of each quadlet
// R13 - inquiry registers are read only; writes change nothing
module camera_capability_inquiry_regs #(
   parameter logic [7:0] FMT_CAPS = cam_inq_pkg::DEF_FMT,
   parameter logic [7:0] MODE_F0_CAPS = cam_inq_pkg::DEF_MODE_F0,
   parameter logic [7:0] MODE_F1_CAPS = cam_inq_pkg::DEF_MODE_FX,
   parameter logic [7:0] MODE_F2_CAPS = cam_inq_pkg::DEF_MODE_FX,
   parameter logic [7:0] MODE_F7_CAPS = cam_inq_pkg::DEF_MODE_FX,
   parameter logic [7:0] RATE_F0M0_CAPS = cam_inq_pkg::DEF_RATE,
   parameter logic [7:0] RATE_F0M1_CAPS = cam_inq_pkg::DEF_RATE,
   parameter logic [7:0] RATE_F0M2_CAPS = cam_inq_pkg::DEF_RATE,
   parameter logic [7:0] RATE_F0M3_CAPS = cam_inq_pkg::DEF_RATE,
   parameter logic [7:0] RATE_F0M4_CAPS = cam_inq_pkg::DEF_RATE
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic ce,
   input wire logic reqValid,
   input wire logic reqWrite,
   input wire logic [31:0] reqAddr,
   input wire logic [31:0] reqWrData,
   output logic respValid_q,
   output logic [3:0] respCode_q,
   output logic [31:0] respData_q,
   output logic initActive_q
);

   // ==========================================================
   // reset synchroniser, kept free of ce so release is never lost
   logic rstMeta_q;
   logic rstN;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rstMeta_q <= 1'b0;
         rstN <= 1'b0;
      end else begin
         rstMeta_q <= 1'b1;
         rstN <= rstMeta_q;
      end
   end

   // ==========================================================
   // inquiry quadlets
   logic [31:0] qFmt;
   logic [31:0] qModeF0;
   logic [31:0] qModeF1;
   logic [31:0] qModeF2;
   logic [31:0] qModeF7;
   logic [31:0] qRate [5];
   logic [7:0] rateCaps [5];
   logic [7:0] rateMask [5];

   // mode 0 of format 0 has no 1.875 and 3.75 fps
   assign rateCaps[0] = RATE_F0M0_CAPS;
   assign rateCaps[1] = RATE_F0M1_CAPS;
   assign rateCaps[2] = RATE_F0M2_CAPS;
   assign rateCaps[3] = RATE_F0M3_CAPS;
   assign rateCaps[4] = RATE_F0M4_CAPS;
   assign rateMask[0] = cam_inq_pkg::MASK_RATE_F0M0; // R10
   assign rateMask[1] = cam_inq_pkg::MASK_FULL; // R10
   assign rateMask[2] = cam_inq_pkg::MASK_FULL;
   assign rateMask[3] = cam_inq_pkg::MASK_FULL;
   assign rateMask[4] = cam_inq_pkg::MASK_FULL;

   // reserved format bits 3..5 are masked off
   inquiry_word uFmt (
      .flags(FMT_CAPS),
      .mask(cam_inq_pkg::MASK_FMT), // R3 R4
      .quad(qFmt)
   );
   inquiry_word uModeF0 (
      .flags(MODE_F0_CAPS),
      .mask(cam_inq_pkg::MASK_MODE_F0), // R5
      .quad(qModeF0)
   );
   inquiry_word uModeF1 (
      .flags(MODE_F1_CAPS),
      .mask(cam_inq_pkg::MASK_FULL), // R6
      .quad(qModeF1)
   );
   inquiry_word uModeF2 (
      .flags(MODE_F2_CAPS),
      .mask(cam_inq_pkg::MASK_FULL), // R6
      .quad(qModeF2)
   );
   inquiry_word uModeF7 (
      .flags(MODE_F7_CAPS),
      .mask(cam_inq_pkg::MASK_FULL), // R8
      .quad(qModeF7)
   );

   // one rate word per format 0 mode 0..4; modes 5 and 6 have none
   for (genvar m = 0; m < 5; m++) begin : g_rate
      inquiry_word uRate (
         .flags(rateCaps[m]),
         .mask(rateMask[m]), // R9
         .quad(qRate[m])
      );
   end

   // ==========================================================
   // address decode and read mux
   logic inBase;
   logic [11:0] offs;
   logic hit;
   logic [31:0] rdData;
   logic initWr;

   assign inBase = reqAddr[31:12] == cam_inq_pkg::CMD_BASE[31:12]; // R1
   assign offs = reqAddr[11:0];

   // unknown offsets answer an address error, never fake data
   always_comb begin
      hit = 1'b1;
      rdData = 32'h00000000;
      if (!inBase || offs[1:0] != 2'h0) begin
         hit = 1'b0; // R1
      end else if (offs >= cam_inq_pkg::OFF_MODE_RSV_LO &&
                   offs <= cam_inq_pkg::OFF_MODE_RSV_HI) begin
         rdData = 32'h00000000; // R7
      end else begin
         case (offs)
            cam_inq_pkg::OFF_INIT: rdData = {initActive_q, 31'h0};
            cam_inq_pkg::OFF_FMT: rdData = qFmt; // R3
            cam_inq_pkg::OFF_MODE_F0: rdData = qModeF0; // R5
            cam_inq_pkg::OFF_MODE_F1: rdData = qModeF1; // R6
            cam_inq_pkg::OFF_MODE_F2: rdData = qModeF2; // R6
            cam_inq_pkg::OFF_MODE_F6: rdData = 32'h00000000; // R7
            cam_inq_pkg::OFF_MODE_F7: rdData = qModeF7; // R8
            cam_inq_pkg::OFF_RATE_F0M0: rdData = qRate[0]; // R10
            cam_inq_pkg::OFF_RATE_F0M1: rdData = qRate[1]; // R9
            cam_inq_pkg::OFF_RATE_F0M2: rdData = qRate[2]; // R9
            cam_inq_pkg::OFF_RATE_F0M3: rdData = qRate[3]; // R9
            cam_inq_pkg::OFF_RATE_F0M4: rdData = qRate[4]; // R9
            default: hit = 1'b0; // R11
         endcase
      end
   end

   assign initWr = reqValid && reqWrite && hit &&
                   offs == cam_inq_pkg::OFF_INIT &&
                   reqWrData[cam_inq_pkg::INIT_BIT];

   // ==========================================================
   // response, one cycle after each request taken while ce is high
   // writes to inquiry offsets complete but store nothing
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         respValid_q <= 1'b0;
         respCode_q <= cam_inq_pkg::RCODE_COMPLETE;
         respData_q <= cam_inq_pkg::RESET_DATA;
      end else if (ce) begin
         respValid_q <= reqValid; // R1
         if (reqValid) begin
            respCode_q <= hit ? cam_inq_pkg::RCODE_COMPLETE
                              : cam_inq_pkg::RCODE_ADDR_ERR;
            respData_q <= (reqWrite || !hit) ? 32'h00000000 : rdData; // R13
         end
      end
   end

   // ==========================================================
   // initialisation sequencer; a new request while busy is ignored
   // rather than restarting, so the pulse lasts INIT_CYCLES cycles with ce high unless reset ends it early
   cam_inq_pkg::initState_t state_q;
   logic [7:0] initCnt_q;

   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         state_q <= cam_inq_pkg::ST_IDLE;
         initCnt_q <= 8'h00;
         initActive_q <= 1'b0;
      end else if (ce) begin
         case (state_q)
            cam_inq_pkg::ST_IDLE: begin
               if (initWr) begin
                  state_q <= cam_inq_pkg::ST_INIT; // R2
                  initCnt_q <= cam_inq_pkg::INIT_CYCLES - 8'h01;
                  initActive_q <= 1'b1; // R2
               end
            end
            cam_inq_pkg::ST_INIT: begin
               if (initCnt_q == 8'h00) begin
                  state_q <= cam_inq_pkg::ST_IDLE;
                  initActive_q <= 1'b0; // R2
               end else begin
                  initCnt_q <= initCnt_q - 8'h01;
               end
            end
            default: begin
               state_q <= cam_inq_pkg::ST_IDLE;
               initActive_q <= 1'b0;
            end
         endcase
      end
   end

   // ==========================================================
   // checks
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstN || !ce);

   logic rdReq;
   logic [7:0] actLen_q;
   assign rdReq = reqValid && !reqWrite && inBase;

   // helper: length of the current initialisation pulse
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         actLen_q <= 8'h00;
      end else if (ce) begin
         actLen_q <= initActive_q ? actLen_q + 8'h01 : 8'h00;
      end
   end

   resp_latency_a: assert property ( // R1
      reqValid && hit |=> respValid_q &&
         respCode_q == cam_inq_pkg::RCODE_COMPLETE)
      else $error("mapped request not completed next cycle");
   unmapped_error_a: assert property ( // R1
      reqValid && !inBase |=> respValid_q &&
         respCode_q == cam_inq_pkg::RCODE_ADDR_ERR)
      else $error("unmapped address not refused");
   init_start_a: assert property ( // R2
      initWr && !initActive_q |=> initActive_q)
      else $error("init write did not start initialisation");
   init_length_a: assert property ( // R2
      $fell(initActive_q) |-> actLen_q == cam_inq_pkg::INIT_CYCLES)
      else $error("initialisation pulse has wrong length");
   fmt_reserved_a: assert property ( // R4
      rdReq && offs == cam_inq_pkg::OFF_FMT |=>
         respData_q[28:26] == 3'h0 && respData_q[23:0] == 24'h0)
      else $error("reserved format bits not zero");
   mode0_top_a: assert property ( // R5
      rdReq && offs == cam_inq_pkg::OFF_MODE_F0 |=>
         respData_q[24:0] == 25'h0)
      else $error("format 0 mode bit 7 or above set");
   mode_f1_a: assert property ( // R6
      rdReq && offs == cam_inq_pkg::OFF_MODE_F1 |=>
         respData_q == {MODE_F1_CAPS[0], MODE_F1_CAPS[1], MODE_F1_CAPS[2],
            MODE_F1_CAPS[3], MODE_F1_CAPS[4], MODE_F1_CAPS[5],
            MODE_F1_CAPS[6], MODE_F1_CAPS[7], 24'h0})
      else $error("format 1 mode word misordered");
   zero_modes_a: assert property ( // R7
      rdReq && offs >= cam_inq_pkg::OFF_MODE_RSV_LO &&
         offs <= cam_inq_pkg::OFF_MODE_F6 && offs[1:0] == 2'h0 |=>
         respData_q == 32'h0 && respCode_q == cam_inq_pkg::RCODE_COMPLETE)
      else $error("reserved mode word not zero");
   rate_slow_a: assert property ( // R10
      rdReq && offs == cam_inq_pkg::OFF_RATE_F0M0 |=>
         respData_q[31:30] == 2'h0 && respData_q[23:0] == 24'h0)
      else $error("mode 0 slow rates reported");
   ro_write_a: assert property ( // R13
      reqValid && reqWrite && hit && offs != cam_inq_pkg::OFF_INIT &&
         !initActive_q |=> !initActive_q && respData_q == 32'h0)
      else $error("inquiry write had an effect");

   // answer strobe is a pulse that only a taken request raises
   resp_pulse_a: assert property ( // R1
      !reqValid |=> !respValid_q)
      else $error("answer without a request");
   // a second init write must not restart the running countdown
   init_no_restart_a: assert property ( // R2
      initWr && initActive_q && initCnt_q != 8'h00 |=>
         initCnt_q == $past(initCnt_q) - 8'h01)
      else $error("init write while busy restarted the pulse");
   mode_f7_a: assert property ( // R8
      rdReq && offs == cam_inq_pkg::OFF_MODE_F7 |=>
         respData_q[23:0] == 24'h0 &&
         respCode_q == cam_inq_pkg::RCODE_COMPLETE)
      else $error("partial image mode word upper bits set");
   rate_low_a: assert property ( // R9
      rdReq && offs >= cam_inq_pkg::OFF_RATE_F0M0 &&
         offs <= cam_inq_pkg::OFF_RATE_F0M4 && offs[1:0] == 2'h0 |=>
         respData_q[23:0] == 24'h0)
      else $error("rate word reserved bits set");

   init_seen_c: cover property ($fell(initActive_q));
   rate_read_c: cover property (rdReq && offs == cam_inq_pkg::OFF_RATE_F0M4);
   err_seen_c: cover property (
      respValid_q && respCode_q == cam_inq_pkg::RCODE_ADDR_ERR);
   b2b_read_c: cover property (rdReq ##1 rdReq);

endmodule : camera_capability_inquiry_regs

// file: verification/host_model.sv
// host side model: issues one quadlet request at a time to the bank
// assumes calls start at a falling clock edge; answers come one edge later
`timescale 1ns/1ps
module host_model (
   input wire logic clk,
   output logic reqValid,
   output logic reqWrite,
   output logic [31:0] reqAddr,
   output logic [31:0] reqWrData,
   input wire logic respValid_q,
   input wire logic [3:0] respCode_q,
   input wire logic [31:0] respData_q
);
   logic gotValid;
   logic [3:0] gotCode;
   logic [31:0] gotData;

   // ==========================================================
   // idle bus
   initial begin
      reqValid = 1'b0;
      reqWrite = 1'b0;
      reqAddr = 32'h00000000;
      reqWrData = 32'h00000000;
   end

   // ==========================================================
   // one request, held over one rising edge, answer caught at the next
   // falling edge while the one-cycle answer strobe still stands
   task quad(input logic wr, input logic [31:0] addr, input logic [31:0] wd);
      reqValid = 1'b1;
      reqWrite = wr;
      reqAddr = addr;
      reqWrData = wr ? wd : ~reqWrData;
      @(negedge clk);
      gotValid = respValid_q;
      gotCode = respCode_q;
      gotData = respData_q;
      // released lines flip so a stale value never looks valid
      reqValid = 1'b0;
      reqWrite = 1'b0;
      reqAddr = ~addr;
      reqWrData = ~reqWrData;
      // idle cycle keeps two calls from touching reqValid in one step
      @(negedge clk);
   endtask : quad
endmodule : host_model

// file: verification/camera_capability_inquiry_regs_bench.sv
// self-checking bench for the capability inquiry register bank
// assumes default capability parameters and a 20-cycle init pulse
`timescale 1ns/1ps
module camera_capability_inquiry_regs_bench;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic ce = 1'b1;
   logic reqValid, reqWrite, respValid_q, initActive_q;
   logic [31:0] reqAddr, reqWrData, respData_q;
   logic [3:0] respCode_q;
   int fails = 0;
   int compares = 0;
   // address, response code, read data
   logic [67:0] rows [17] = '{
      {32'hf0f00100, 4'h0, 32'he1000000}, {32'hf0f00180, 4'h0, 32'hfe000000},
      {32'hf0f00184, 4'h0, 32'hff000000}, {32'hf0f00188, 4'h0, 32'hff000000},
      {32'hf0f0018c, 4'h0, 32'h00000000}, {32'hf0f00190, 4'h0, 32'h00000000},
      {32'hf0f00194, 4'h0, 32'h00000000}, {32'hf0f00198, 4'h0, 32'h00000000},
      {32'hf0f0019c, 4'h0, 32'hff000000}, {32'hf0f00200, 4'h0, 32'h3f000000},
      {32'hf0f00204, 4'h0, 32'hff000000}, {32'hf0f00208, 4'h0, 32'hff000000},
      {32'hf0f0020c, 4'h0, 32'hff000000}, {32'hf0f00210, 4'h0, 32'hff000000},
      {32'hf0f00300, 4'h7, 32'h00000000}, {32'hf0f00101, 4'h7, 32'h00000000},
      {32'hf0f10100, 4'h7, 32'h00000000}};

   // ==========================================================
   // clock, 50 ns period
   always #25 clk = ~clk;

   camera_capability_inquiry_regs uut (
      .clk(clk), .nrst(nrst), .ce(ce), .reqValid(reqValid),
      .reqWrite(reqWrite), .reqAddr(reqAddr), .reqWrData(reqWrData),
      .respValid_q(respValid_q), .respCode_q(respCode_q),
      .respData_q(respData_q), .initActive_q(initActive_q));

   host_model host (
      .clk(clk), .reqValid(reqValid), .reqWrite(reqWrite),
      .reqAddr(reqAddr), .reqWrData(reqWrData),
      .respValid_q(respValid_q), .respCode_q(respCode_q),
      .respData_q(respData_q));

   // ==========================================================
   // comparison and verdict
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         fails++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   task wrap_up;
      if (fails == 0 && compares > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : wrap_up

   // read and check valid, code and data together
   task rd(input logic [31:0] a, input logic [3:0] c, input logic [31:0] d);
      host.quad(1'b0, a, 32'h00000000);
      chk({31'h0, host.gotValid}, 32'h1);
      chk({28'h0, host.gotCode}, {28'h0, c});
      chk(host.gotData, d);
   endtask : rd

   // ==========================================================
   // watchdog: the whole run needs well under 20 us
   initial begin
      #100000;
      fails++;
      wrap_up();
   end

   // ==========================================================
   // main sequence
   initial begin
      repeat (10) @(negedge clk);
      chk({26'h0, respValid_q, respCode_q, initActive_q}, 32'h0);
      chk(respData_q, 32'h00000000);
      nrst = 1'b1;
      repeat (3) @(negedge clk);
      foreach (rows[i]) begin
         rd(rows[i][67:36], rows[i][35:32], rows[i][31:0]);
      end
      // writes to an inquiry register are answered but change nothing
      host.quad(1'b1, 32'hf0f00100, 32'hffffffff);
      chk({28'h0, host.gotCode}, 32'h0);
      chk(host.gotData, 32'h00000000);
      rd(32'hf0f00100, 4'h0, 32'he1000000);
      // msb clear does not start init
      host.quad(1'b1, 32'hf0f00000, 32'h7fffffff);
      chk({31'h0, initActive_q}, 32'h0);
      // request with clock enable low is never taken
      ce = 1'b0;
      host.quad(1'b0, 32'hf0f00100, 32'h0);
      chk({31'h0, host.gotValid}, 32'h0);
      ce = 1'b1;
      // init: busy from c1 to c20, a second request mid-run is ignored
      host.quad(1'b1, 32'hf0f00000, 32'h80000000);
      chk({31'h0, initActive_q}, 32'h1);
      rd(32'hf0f00000, 4'h0, 32'h80000000);
      host.quad(1'b1, 32'hf0f00000, 32'h80000000);
      chk({28'h0, host.gotCode}, 32'h0);
      // last busy cycle is c20, first idle one c21
      repeat (14) @(negedge clk);
      chk({31'h0, initActive_q}, 32'h1);
      @(negedge clk);
      chk({31'h0, initActive_q}, 32'h0);
      rd(32'hf0f00000, 4'h0, 32'h00000000);
      // reset in mid-run clears a running init and the answer lines
      host.quad(1'b1, 32'hf0f00000, 32'h80000000);
      chk({31'h0, initActive_q}, 32'h1);
      nrst = 1'b0;
      @(negedge clk);
      chk({26'h0, respValid_q, respCode_q, initActive_q}, 32'h0);
      chk(respData_q, 32'h00000000);
      nrst = 1'b1;
      repeat (3) @(negedge clk);
      rd(32'hf0f00000, 4'h0, 32'h00000000);
      rd(32'hf0f00100, 4'h0, 32'he1000000);
      wrap_up();
   end
endmodule : camera_capability_inquiry_regs_bench
